// ===== bench/cpu_interrupt_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_sequencer_test
    import irq_seq_pkg::*;
;
    // stimulus
    logic I_REF_CLK = '0, I_RST = '1, I_AWVALID = '0, I_WVALID = '0, I_BREADY = '0, I_ARVALID = '0;
    logic I_RREADY = '0, I_INSTR_DONE = '0, I_OP_SEI = '0, I_OP_CLI = '0, I_OP_RETURN_FROM_IRQ = '0;
    logic I_SLEEPING = '0, I_ALU_FLAGS_WE = '0;
    logic [ADDR_W-1:0] I_AWADDR = '0, I_ARADDR = '0;
    logic [31:0] I_WDATA = '0, r;
    logic [3:0] I_WSTRB = 4'hF, I_SRC_EVENT = '0, I_SRC_LEVEL = '0;
    logic [PC_W-1:0] I_NEXT_PC = '0;
    logic [6:0] I_ALU_FLAGS = '0, alu;
    // outputs
    wire logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_STALL, O_PC_LOAD;
    wire logic O_HANDLER_START, O_STK_WE, O_STK_RE;
    wire logic [1:0] O_BRESP, O_RRESP;
    wire logic [31:0] O_RDATA;
    wire logic [PC_W-1:0] O_PC_VALUE;
    wire logic [7:0] O_STATUS_FLAGS, O_STK_WDATA, I_STK_RDATA;
    wire logic [SP_W-1:0] O_STK_ADDR;
    int error_cnt = 0, check_count = 0, seed = 32;
    logic [33:0] pq[$], rq[$];
    logic [1:0] bq[$];
    irq_sequencer i_dut (.*);
    stack_mem_model i_stk (.clk(I_REF_CLK), .we(O_STK_WE), .re(O_STK_RE), .addr(O_STK_ADDR),
        .wdata(O_STK_WDATA), .rdata(I_STK_RDATA));
    always #50 I_REF_CLK = ~I_REF_CLK;
    task cyc(input int n);
        repeat (n) @(posedge I_REF_CLK);
    endtask
    task check(input logic [33:0] g, input logic [33:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task check_pc(input logic [PC_W-1:0] g, input logic [33:0] e);
        check({23'h0, g}, e);
    endtask
    task check_resp(input logic [1:0] g, input logic [1:0] e);
        check({32'h0, g}, {32'h0, e});
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // bus write: each channel dropped when taken, done at the response
    task wr(input logic [7:0] a, input logic [31:0] d);
        bq.push_back(RESP_OKAY);
        cyc(1);
        {I_AWADDR, I_WDATA, I_AWVALID, I_WVALID, I_BREADY} <= {a, d, 3'h7};
        for (int k = 0; k < 40; k++) begin
            cyc(1);
            if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
            if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
            if (O_BVALID === 1'b1) begin
                I_BREADY <= 1'b0;
                return;
            end
        end
        error_cnt++;
        end_of_test;
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        cyc(1);
        {I_ARADDR, I_ARVALID, I_RREADY} <= {a, 2'h3};
        for (int k = 0; k < 40; k++) begin
            cyc(1);
            if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
            if (O_RVALID === 1'b1) begin
                I_RREADY <= 1'b0;
                return;
            end
        end
        error_cnt++;
        end_of_test;
    endtask
    // one instruction boundary; op is {return_from_irq, sei, cli, done}; waits out any stall
    task instr(input logic [3:0] op, input logic [PC_W-1:0] pc);
        cyc(1);
        {I_OP_RETURN_FROM_IRQ, I_OP_SEI, I_OP_CLI, I_INSTR_DONE, I_NEXT_PC} <= {op, pc};
        cyc(1);
        {I_OP_RETURN_FROM_IRQ, I_OP_SEI, I_OP_CLI, I_INSTR_DONE} <= 4'h0;
        for (int k = 0; k < 40; k++) begin
            cyc(2);
            if (O_STALL === 1'b0) begin
                cyc(4);
                return;
            end
        end
        error_cnt++;
        end_of_test;
    endtask
    // watcher: every load and read answer takes the oldest note
    always @(posedge I_REF_CLK) begin
        if (O_PC_LOAD === 1'b1) check_pc(O_PC_VALUE, pq.size() ? pq.pop_front() : '1);
        if (O_RVALID === 1'b1 && I_RREADY) check({O_RRESP, O_RDATA}, rq.pop_front());
        if (O_BVALID === 1'b1 && I_BREADY) check_resp(O_BRESP, bq.pop_front());
    end
    initial begin
        pq.push_back(34'h0);
        cyc(20);
        I_RST <= 1'b0;
        wr(ADDR_ENABLE, 32'hFF);
        r = $random(seed);
        alu = r[6:0];
        cyc(1);
        {I_SRC_EVENT, I_ALU_FLAGS_WE, I_ALU_FLAGS} <= {5'h1D, alu};
        cyc(1);
        {I_SRC_EVENT, I_ALU_FLAGS_WE} <= 5'h0;
        instr(4'h1, 11'h010);
        rd(ADDR_FLAGS, 34'h0E);
        wr(ADDR_FLAGS, 32'h8);
        rd(ADDR_FLAGS, 34'h06);
        instr(4'h5, 11'h020);
        for (int i = 1; i < 3; i++) begin
            r = $random(seed);
            pq.push_back(34'(VEC_BASE) + 34'(i));
            pq.push_back({23'h0, r[10:0]});
            instr(4'h1, r[10:0]);
            instr(4'h9, 11'h000);
        end
        rd(ADDR_STATUS, {27'h1, alu});
        I_SRC_LEVEL <= 4'h1;
        instr(4'h3, 11'h030);
        I_SRC_LEVEL <= 4'h0;
        rd(ADDR_STATUS, {27'h0, alu});
        wr(ADDR_STATUS, {25'h1, alu});
        instr(4'h1, 11'h040);
        rd(8'h20, {RESP_SLVERR, 32'h0});
        rd(ADDR_SP, {18'h0, SP_RESET});
        // sleeping core woken by external_irq_zero, the top-priority source
        pq.push_back(34'(VEC_BASE));
        pq.push_back(34'h050);
        I_SRC_EVENT <= 4'h1;
        cyc(1);
        {I_SLEEPING, I_SRC_EVENT, I_NEXT_PC} <= {5'h10, 11'h050};
        instr(4'h0, 11'h050);
        I_SLEEPING <= 1'b0;
        instr(4'h9, 11'h000);
        cyc(10);
        check(34'(pq.size()), 34'h0);
        end_of_test;
    end
endmodule
`default_nettype wire

// ===== bench/irq_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module irq_seq_monitor
    import irq_seq_pkg::*;
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // watched ports
    input wire logic I_OP_CLI,
    input wire logic I_SLEEPING,
    input wire logic O_STALL,
    input wire logic O_PC_LOAD,
    input wire logic O_HANDLER_START,
    input wire logic [7:0] O_STATUS_FLAGS,
    input wire logic O_STK_WE,
    input wire logic O_STK_RE,
    input wire logic [SP_W-1:0] O_STK_ADDR
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    // two stack strobes, then the load
    sequence push_s;
        O_STK_WE ##1 O_STK_WE ##2 O_PC_LOAD;
    endsequence
    sequence pop_s;
        O_STK_RE ##1 O_STK_RE ##3 O_PC_LOAD;
    endsequence
    // a load three cycles after a pop marks a return
    a_entry_push: assert property ($rose(O_STK_WE) |-> push_s ##3 O_HANDLER_START)
        else $error("entry");
    a_entry_stall: assert property ($rose(O_STK_WE) |-> O_STALL [*3] ##1 !O_STALL)
        else $error("stall");
    a_push_down: assert property ($rose(O_STK_WE) |=> O_STK_ADDR == $past(O_STK_ADDR) - SP_ONE)
        else $error("push");
    a_entry_gie: assert property ($rose(O_STK_WE) |=> !O_STATUS_FLAGS[7])
        else $error("gie");
    a_return_pop: assert property ($rose(O_STK_RE) |-> pop_s)
        else $error("pop");
    a_return_gie: assert property (O_PC_LOAD && $past(O_STK_RE, 3) |=> O_STATUS_FLAGS[7])
        else $error("return_from_irq");
    a_return_gap: assert property (O_PC_LOAD && $past(O_STK_RE, 3) |=> !$rose(O_STALL))
        else $error("gap");
    a_cli_block: assert property (I_OP_CLI |=> !$rose(O_STALL))
        else $error("cli");
    // a wake adds four idle cycles before the first push
    a_wake_delay: assert property ($rose(O_STALL) && $past(I_SLEEPING) |-> !O_STK_WE [*5] ##1 O_STK_WE)
        else $error("wake");
endmodule
bind irq_sequencer irq_seq_monitor i_mon (.*);
`default_nettype wire

// ===== bench/stack_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model (
    // core side
    input wire logic clk,
    input wire logic we,
    input wire logic re,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [512];
    initial rdata = 8'h5A;
    // data one cycle after the strobe; idle line wanders so stale bytes never match
    always @(posedge clk) begin
        if (we) mem_q[addr[8:0]] <= wdata;
        rdata <= re ? mem_q[addr[8:0]] : ~rdata;
    end
endmodule
`default_nettype wire

// ===== hw/axil_regport.sv
`timescale 1ns/1ps
`default_nettype none
module axil_regport
    import irq_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    output logic wr_stb,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic aw_have_q;
    logic w_have_q;
    logic rd_pend_q;

    // write path: address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            wr_stb <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            wr_stb <= 1'b0;
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                wready <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (aw_have_q && w_have_q && !wr_stb && !bvalid) begin
                wr_stb <= 1'b1;
            end
            if (wr_stb) begin
                bvalid <= 1'b1;
                bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read path: data sampled one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            arready <= 1'b1;
            rd_addr <= '0;
            rd_pend_q <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            rd_pend_q <= 1'b0;
            if (arvalid && arready) begin
                arready <= 1'b0;
                rd_addr <= araddr;
                rd_pend_q <= 1'b1;
            end
            if (rd_pend_q) begin
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== hw/irq_seq_pkg.sv
package irq_seq_pkg;

    // ------------------------------------------------------------
    // sources and widths
    // ------------------------------------------------------------
    localparam int SRC_N = 8;                     // sources, index 0 is external_irq_zero
    localparam int FLAG_N = 4;                    // sources 0..3 keep a flag, 4..7 are level-type
    localparam int LEVEL_N = SRC_N - FLAG_N;
    localparam int PC_W = 11;                     // 2048 program words
    localparam int SP_W = 16;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 8;
    localparam int GIE_POS = 7;                   // global enable inside status_flags_reg

    // ------------------------------------------------------------
    // vectors and reset values
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0] RESET_VEC = 11'h000;
    localparam logic [PC_W-1:0] VEC_BASE = 11'h001; // source i vectors to VEC_BASE + i
    localparam logic [SP_W-1:0] SP_RESET = 16'h015F; // last SRAM address
    localparam logic [SP_W-1:0] SP_ONE = 16'h0001;
    localparam logic [SP_W-1:0] SP_TWO = 16'h0002;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [SRC_N-1:0] ENABLE_RESET = 8'h00;

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam logic [3:0] ENTRY_CYC = 4'h4;
    localparam logic [3:0] WAKE_CYC = 4'h4;
    localparam logic [3:0] RETURN_CYC = 4'h4;
    localparam logic [3:0] JUMP_CYC = 4'h3;
    localparam logic [3:0] CYC_ZERO = 4'h0;
    localparam logic [3:0] CYC_ONE = 4'h1;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SP = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_WAKE = 4'h2,
        ST_ENTRY = 4'h4,
        ST_RETURN = 4'h8
    } seq_state_t;

endpackage

// ===== hw/irq_sequencer.sv
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module irq_sequencer
    import irq_seq_pkg::*;
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // register bus
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // interrupt sources
    input wire logic [FLAG_N-1:0] I_SRC_EVENT,
    input wire logic [LEVEL_N-1:0] I_SRC_LEVEL,
    // instruction sequencer
    input wire logic I_INSTR_DONE,
    input wire logic [PC_W-1:0] I_NEXT_PC,
    input wire logic I_OP_SEI,
    input wire logic I_OP_CLI,
    input wire logic I_OP_RETURN_FROM_IRQ,
    input wire logic I_SLEEPING,
    input wire logic I_ALU_FLAGS_WE,
    input wire logic [6:0] I_ALU_FLAGS,
    output logic O_STALL,
    output logic O_PC_LOAD,
    output logic [PC_W-1:0] O_PC_VALUE,
    output logic O_HANDLER_START,
    output logic [7:0] O_STATUS_FLAGS,
    // stack memory
    output logic O_STK_WE,
    output logic O_STK_RE,
    output logic [SP_W-1:0] O_STK_ADDR,
    output logic [7:0] O_STK_WDATA,
    input wire logic [7:0] I_STK_RDATA
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    seq_state_t state_q;
    logic [3:0] cnt_q;
    logic [3:0] jmp_cnt_q;
    logic jmp_busy_q;
    logic boot_q;
    logic [7:0] status_q;
    logic [SRC_N-1:0] enable_q;
    logic [FLAG_N-1:0] flag_q;
    logic [SP_W-1:0] sp_q;
    logic [PC_W-1:0] ret_pc_q;
    logic [PC_W-1:0] vec_q;
    logic [PC_W-1:0] last_vec_q;
    logic [IDX_W-1:0] win_idx;
    logic [SRC_N-1:0] pending;
    logic [SRC_N-1:0] source_req;
    logic win_any;
    logic boundary;
    logic accept;
    logic ret_start;
    logic entry_last;
    logic ret_last;
    logic gie;
    logic wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic [FLAG_N-1:0] flag_w1c;
    logic [FLAG_N-1:0] flag_hw_clr;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    axil_regport u_regport (
        .clk(I_REF_CLK),
        .rst(I_RST),
        .awaddr(I_AWADDR),
        .awvalid(I_AWVALID),
        .awready(O_AWREADY),
        .wdata(I_WDATA),
        .wstrb(I_WSTRB),
        .wvalid(I_WVALID),
        .wready(O_WREADY),
        .bresp(O_BRESP),
        .bvalid(O_BVALID),
        .bready(I_BREADY),
        .araddr(I_ARADDR),
        .arvalid(I_ARVALID),
        .arready(O_ARREADY),
        .rdata(O_RDATA),
        .rresp(O_RRESP),
        .rvalid(O_RVALID),
        .rready(I_RREADY),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // unmapped addresses answer with an error
    assign wr_err = !(wr_addr == ADDR_STATUS || wr_addr == ADDR_ENABLE || wr_addr == ADDR_FLAGS ||
                      wr_addr == ADDR_SP || wr_addr == ADDR_STATE);
    assign rd_err = !(rd_addr == ADDR_STATUS || rd_addr == ADDR_ENABLE || rd_addr == ADDR_FLAGS ||
                      rd_addr == ADDR_SP || rd_addr == ADDR_STATE);

    // read mux, reserved bits read as zero
    always_comb begin
        case (rd_addr)
            ADDR_STATUS: rd_data = {24'h000000, status_q};
            ADDR_ENABLE: rd_data = {24'h000000, enable_q};
            ADDR_FLAGS: rd_data = {24'h000000, I_SRC_LEVEL, flag_q};
            ADDR_SP: rd_data = {16'h0000, sp_q};
            ADDR_STATE: rd_data = {17'h00000, last_vec_q, state_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    assign gie = status_q[GIE_POS];
    // flag sources use the stored flag, level sources the live condition
    assign source_req = {I_SRC_LEVEL, flag_q};
    assign pending = source_req & enable_q;

    lowest_pick u_pick (
        .i_req(pending),
        .o_any(win_any),
        .o_idx(win_idx)
    );

    // a sleeping core has no instruction in flight, so it is always at a boundary
    assign boundary = I_INSTR_DONE || I_SLEEPING;
    // registered gie: an enable in this very instruction is seen one boundary late
    assign accept = (state_q == ST_RUN) && !boot_q && boundary && gie && win_any &&
                    !O_PC_LOAD && !I_OP_CLI && !I_OP_RETURN_FROM_IRQ;
    assign ret_start = (state_q == ST_RUN) && !boot_q && I_INSTR_DONE && I_OP_RETURN_FROM_IRQ;
    assign entry_last = (state_q == ST_ENTRY) && (cnt_q == ENTRY_CYC - CYC_ONE);
    assign ret_last = (state_q == ST_RETURN) && (cnt_q == RETURN_CYC - CYC_ONE);

    // ------------------------------------------------------------
    // sequence state
    // ------------------------------------------------------------
    // entry, optional wake delay and return each hold the core stalled
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state_q <= ST_RUN;
            cnt_q <= CYC_ZERO;
            O_STALL <= 1'b0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    cnt_q <= CYC_ZERO;
                    if (ret_start) begin
                        state_q <= ST_RETURN;
                        O_STALL <= 1'b1;
                    end else if (accept) begin
                        state_q <= I_SLEEPING ? ST_WAKE : ST_ENTRY;
                        O_STALL <= 1'b1;
                    end
                end
                ST_WAKE: begin
                    cnt_q <= cnt_q + CYC_ONE;
                    if (cnt_q == WAKE_CYC - CYC_ONE) begin
                        state_q <= ST_ENTRY;
                        cnt_q <= CYC_ZERO;
                    end
                end
                ST_ENTRY: begin
                    cnt_q <= cnt_q + CYC_ONE;
                    if (entry_last) begin
                        state_q <= ST_RUN;
                        O_STALL <= 1'b0;
                    end
                end
                ST_RETURN: begin
                    cnt_q <= cnt_q + CYC_ONE;
                    if (ret_last) begin
                        state_q <= ST_RUN;
                        O_STALL <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                    O_STALL <= 1'b0;
                end
            endcase
        end
    end

    // winner and return address are frozen at acceptance
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            vec_q <= RESET_VEC;
            ret_pc_q <= RESET_VEC;
            last_vec_q <= RESET_VEC;
        end else if (accept) begin
            vec_q <= VEC_BASE + PC_W'(win_idx);
            last_vec_q <= VEC_BASE + PC_W'(win_idx);
            ret_pc_q <= I_NEXT_PC;
        end
    end

    // ------------------------------------------------------------
    // stack port and stack pointer
    // ------------------------------------------------------------
    // low byte goes first on entry, so the high byte is popped first
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_STK_WE <= 1'b0;
            O_STK_RE <= 1'b0;
            O_STK_ADDR <= SP_RESET;
            O_STK_WDATA <= 8'h00;
        end else begin
            O_STK_WE <= 1'b0;
            O_STK_RE <= 1'b0;
            if (state_q == ST_ENTRY && cnt_q == CYC_ZERO) begin
                O_STK_WE <= 1'b1;
                O_STK_ADDR <= sp_q;
                O_STK_WDATA <= ret_pc_q[7:0];
            end else if (state_q == ST_ENTRY && cnt_q == CYC_ONE) begin
                O_STK_WE <= 1'b1;
                O_STK_ADDR <= sp_q;
                O_STK_WDATA <= {5'h00, ret_pc_q[PC_W-1:8]};
            end else if (ret_start) begin
                O_STK_RE <= 1'b1;
                O_STK_ADDR <= sp_q + SP_ONE;
            end else if (state_q == ST_RETURN && cnt_q == CYC_ZERO) begin
                O_STK_RE <= 1'b1;
                O_STK_ADDR <= sp_q + SP_TWO;
            end
        end
    end

    // each push lowers sp by one; the pop adds two at the end of return
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            sp_q <= SP_RESET;
        end else if (state_q == ST_ENTRY && (cnt_q == CYC_ZERO || cnt_q == CYC_ONE)) begin
            sp_q <= sp_q - SP_ONE;
        end else if (ret_last) begin
            sp_q <= sp_q + SP_TWO;
        end else if (wr_stb && wr_addr == ADDR_SP) begin
            // a software write to sp is dropped only in the two push cycles and the last return cycle
            if (wr_strb[0]) begin
                sp_q[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
                sp_q[15:8] <= wr_data[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // program counter redirect
    // ------------------------------------------------------------
    // read data lags the read strobe by one cycle
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            boot_q <= 1'b1;
            O_PC_LOAD <= 1'b0;
            O_PC_VALUE <= RESET_VEC;
        end else begin
            boot_q <= 1'b0;
            O_PC_LOAD <= 1'b0;
            if (boot_q) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VALUE <= RESET_VEC;
            end else if (entry_last) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VALUE <= vec_q;
            end else if (state_q == ST_RETURN && cnt_q == CYC_ONE) begin
                O_PC_VALUE[PC_W-1:8] <= I_STK_RDATA[2:0];
            end else if (state_q == ST_RETURN && cnt_q == CYC_ONE + CYC_ONE) begin
                O_PC_VALUE[7:0] <= I_STK_RDATA;
            end else if (ret_last) begin
                // the core runs one instruction here before any new entry
                O_PC_LOAD <= 1'b1;
            end
        end
    end

    // handler start marks the end of the vector jump
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            jmp_busy_q <= 1'b0;
            jmp_cnt_q <= CYC_ZERO;
            O_HANDLER_START <= 1'b0;
        end else begin
            O_HANDLER_START <= 1'b0;
            if (entry_last) begin
                jmp_busy_q <= 1'b1;
                jmp_cnt_q <= CYC_ZERO;
            end else if (jmp_busy_q) begin
                jmp_cnt_q <= jmp_cnt_q + CYC_ONE;
                if (jmp_cnt_q == JUMP_CYC - CYC_ONE) begin
                    jmp_busy_q <= 1'b0;
                    O_HANDLER_START <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // status flags register
    // ------------------------------------------------------------
    // later assignments win: hardware events override software writes
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            status_q <= STATUS_RESET;
        end else begin
            if (wr_stb && wr_addr == ADDR_STATUS && wr_strb[0]) begin
                status_q <= wr_data[7:0];
            end
            if (I_ALU_FLAGS_WE) begin
                status_q[6:0] <= I_ALU_FLAGS;
            end
            if (I_INSTR_DONE && I_OP_SEI) begin
                status_q[GIE_POS] <= 1'b1;
            end
            if (I_INSTR_DONE && I_OP_CLI) begin
                status_q[GIE_POS] <= 1'b0;
            end
            if (accept) begin
                status_q[GIE_POS] <= 1'b0;
            end
            if (ret_last) begin
                status_q[GIE_POS] <= 1'b1;
            end
        end
    end

    // mirror for the core's own reads
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_STATUS_FLAGS <= STATUS_RESET;
        end else begin
            O_STATUS_FLAGS <= status_q;
        end
    end

    // ------------------------------------------------------------
    // enables and flags
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_stb && wr_addr == ADDR_ENABLE && wr_strb[0]) begin
            enable_q <= wr_data[SRC_N-1:0];
        end
    end

    // a new event in the clearing cycle survives, so no request is lost
    genvar g;
    generate
        for (g = 0; g < FLAG_N; g++) begin : g_flag
            assign flag_w1c[g] = wr_stb && wr_addr == ADDR_FLAGS && wr_strb[0] && wr_data[g];
            assign flag_hw_clr[g] = accept && win_idx == IDX_W'(g);
            always_ff @(posedge I_REF_CLK) begin
                if (I_RST) begin
                    flag_q[g] <= 1'b0;
                end else if (I_SRC_EVENT[g]) begin
                    flag_q[g] <= 1'b1;
                end else if (flag_w1c[g] || flag_hw_clr[g]) begin
                    flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ===== hw/lowest_pick.sv
`timescale 1ns/1ps
`default_nettype none
module lowest_pick
    import irq_seq_pkg::*;
(
    // request vector
    input wire logic [SRC_N-1:0] i_req,
    // winner
    output logic o_any,
    output logic [IDX_W-1:0] o_idx
);

    // scan from the top so the lowest index is written last and wins
    always_comb begin
        o_any = 1'b0;
        o_idx = '0;
        for (int k = SRC_N - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                o_any = 1'b1;
                o_idx = IDX_W'(k);
            end
        end
    end

endmodule
`default_nettype wire
